/* File: rtl/pmrs_top.sv */
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pmrs_consts.svh"
module pmrs_top #(
  parameter int unsigned PWRUP0_CYC = 32'(64'(`PMRS_PWRUP0_PS) / `PMRS_CLK_PS),
  parameter int unsigned PWRUP1_CYC = 32'(64'(`PMRS_PWRUP1_PS) / `PMRS_CLK_PS),
  parameter int unsigned PWRUP2_CYC = 32'(64'(`PMRS_PWRUP2_PS) / `PMRS_CLK_PS),
  parameter int unsigned PWRUP3_CYC = 32'(64'(`PMRS_PWRUP3_PS) / `PMRS_CLK_PS),
  parameter int unsigned PWRUP4_CYC = 32'(64'(`PMRS_PWRUP4_PS) / `PMRS_CLK_PS)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset events
  input wire logic por_event,
  input wire logic low_voltage_reset,
  input wire logic reset_pin_n,
  input wire logic wdt_timeout,
  // Configuration and core events
  input wire pmrs_pkg::pmrs_cfg_s cfg,
  input wire pmrs_pkg::pmrs_wake_s wake,
  input wire logic halt_instruction,
  input wire logic watchdog_clear_instruction,
  input wire logic irq_enable_instruction,
  input wire logic irq_disable_instruction,
  // Peripheral enables
  input wire logic timer0_run,
  input wire logic timer1_run,
  input wire logic watchdog_run_enable,
  // Clock and run control
  output logic core_reset,
  output logic cpu_run,
  output logic inst_tick,
  output logic sys_clk_fast,
  output logic fast_osc_en,
  output logic slow_osc_en,
  output logic timer0_en,
  output logic timer1_en,
  output logic timer0_slow_clk,
  output logic periph_en,
  output logic wdt_active,
  output logic wdt_clear,
  output logic irq_vector
);

  // ****************************************
  // Decode
  // ****************************************
  pmrs_pkg::pmrs_state_e state_reg;
  logic fast_osc_select_reg;
  logic fast_osc_stop_reg;
  logic [1:0] power_mode_field_reg;
  logic low_clock_to_timer0_reg;
  logic timeout_flag_n_reg;
  logic powerdown_flag_n_reg;
  logic global_irq_enable_reg;
  logic [26:0] pwrup_cnt_reg;
  logic [3:0] cnt_reg;
  logic [1:0] div_reg;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic wdt_clear_reg;
  logic irq_vector_reg;
  logic rst_evt;
  logic halted;
  logic in_reset;
  logic wr_done;
  logic wr_ctrl;
  logic mapped;
  logic enter_halt;
  logic enter_stby;
  logic stby_wake;
  logic halt_wake;
  logic [26:0] pwrup_len;

  assign rst_evt = por_event | low_voltage_reset | ~reset_pin_n
    | (wdt_timeout & cfg.wdt_reset_mode);
  assign halted = (state_reg == pmrs_pkg::ST_HALT)
    || (state_reg == pmrs_pkg::ST_WAKE);
  assign in_reset = (state_reg == pmrs_pkg::ST_RESET)
    || (state_reg == pmrs_pkg::ST_PWRUP) || (state_reg == pmrs_pkg::ST_OST);
  assign mapped = (paddr == `PMRS_CTRL_OFS) || (paddr == `PMRS_STAT_OFS);
  assign wr_done = psel && penable && pready_reg && pwrite;
  assign wr_ctrl = wr_done && (paddr == `PMRS_CTRL_OFS)
    && (state_reg == pmrs_pkg::ST_RUN);
  assign enter_halt = (state_reg == pmrs_pkg::ST_RUN) && !rst_evt
    && (halt_instruction || (wr_ctrl
    && pwdata[`PMRS_MODE_LSB+:2] == `PMRS_MODE_HALT));
  assign enter_stby = (state_reg == pmrs_pkg::ST_RUN) && !rst_evt
    && !halt_instruction && wr_ctrl
    && (pwdata[`PMRS_MODE_LSB+:2] == `PMRS_MODE_STBY);
  assign stby_wake = wake.t0_ovf | wake.t1_unf | wake.wdt_irq
    | wake.pb_change | wake.ext_irq | wake.lvd_irq;
  assign halt_wake = wake.wdt_irq | wake.pb_change | wake.ext_irq;

  always_comb
  begin
    case (cfg.pwrup_sel)
      3'h0: pwrup_len = 27'(PWRUP0_CYC);
      3'h1: pwrup_len = 27'(PWRUP1_CYC);
      3'h2: pwrup_len = 27'(PWRUP2_CYC);
      3'h3: pwrup_len = 27'(PWRUP3_CYC);
      default: pwrup_len = 27'(PWRUP4_CYC);
    endcase
  end

  // ****************************************
  // Mode sequencer
  // ****************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= pmrs_pkg::ST_RESET;
      cnt_reg <= 4'h0;
      pwrup_cnt_reg <= 27'h0;
    end
    else if (rst_evt)
    begin
      state_reg <= pmrs_pkg::ST_RESET;
      cnt_reg <= 4'h0;
      pwrup_cnt_reg <= 27'h0;
    end
    else
    begin
      case (state_reg)
        pmrs_pkg::ST_RESET:
        begin
          state_reg <= pmrs_pkg::ST_PWRUP;
          pwrup_cnt_reg <= 27'h0;
        end
        pmrs_pkg::ST_PWRUP:
        begin
          if (pwrup_cnt_reg + 27'h1 >= pwrup_len)
          begin
            state_reg <= pmrs_pkg::ST_OST;
            cnt_reg <= 4'h0;
          end
          else
          begin
            pwrup_cnt_reg <= pwrup_cnt_reg + 27'h1;
          end
        end
        pmrs_pkg::ST_OST:
        begin
          if (cnt_reg == `PMRS_OST_CYC)
          begin
            state_reg <= pmrs_pkg::ST_RUN;
          end
          cnt_reg <= cnt_reg + 4'h1;
        end
        pmrs_pkg::ST_RUN:
        begin
          if (enter_halt)
          begin
            state_reg <= pmrs_pkg::ST_HALT;
          end
          else if (enter_stby)
          begin
            state_reg <= pmrs_pkg::ST_STANDBY;
          end
        end
        pmrs_pkg::ST_STANDBY:
        begin
          if (stby_wake)
          begin
            state_reg <= pmrs_pkg::ST_RUN;
          end
        end
        pmrs_pkg::ST_HALT:
        begin
          if (halt_wake)
          begin
            state_reg <= pmrs_pkg::ST_WAKE;
            cnt_reg <= 4'h0;
          end
        end
        pmrs_pkg::ST_WAKE:
        begin
          if (cnt_reg == `PMRS_WAKE_CYC)
          begin
            state_reg <= pmrs_pkg::ST_RUN;
          end
          cnt_reg <= cnt_reg + 4'h1;
        end
        default:
        begin
          state_reg <= pmrs_pkg::ST_RESET;
        end
      endcase
    end
  end

  // ****************************************
  // Oscillator control register
  // ****************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fast_osc_select_reg <= 1'b1;
      fast_osc_stop_reg <= 1'b0;
      power_mode_field_reg <= `PMRS_MODE_RUN;
      low_clock_to_timer0_reg <= 1'b0;
    end
    else if (rst_evt || in_reset)
    begin
      fast_osc_select_reg <= cfg.startup_fast;
      fast_osc_stop_reg <= 1'b0;
      power_mode_field_reg <= `PMRS_MODE_RUN;
      low_clock_to_timer0_reg <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      fast_osc_select_reg <= pwdata[`PMRS_SEL_BIT];
      fast_osc_stop_reg <= pwdata[`PMRS_STOP_BIT];
      power_mode_field_reg <= pwdata[`PMRS_MODE_LSB+:2];
      low_clock_to_timer0_reg <= pwdata[`PMRS_LCK_BIT];
    end
    else if (halt_instruction && state_reg == pmrs_pkg::ST_RUN)
    begin
      power_mode_field_reg <= `PMRS_MODE_HALT;
    end
    else if (state_reg == pmrs_pkg::ST_RUN)
    begin
      power_mode_field_reg <= `PMRS_MODE_RUN;
    end
  end

  // ****************************************
  // Timeout and power-down flags
  // ****************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      timeout_flag_n_reg <= 1'b1;
      powerdown_flag_n_reg <= 1'b1;
    end
    else if (por_event || low_voltage_reset)
    begin
      timeout_flag_n_reg <= 1'b1;
      powerdown_flag_n_reg <= 1'b1;
    end
    else if (!reset_pin_n)
    begin
      if (halted)
      begin
        timeout_flag_n_reg <= 1'b1;
        powerdown_flag_n_reg <= 1'b1;
      end
    end
    else if (wdt_timeout)
    begin
      timeout_flag_n_reg <= 1'b0;
      if (cfg.wdt_reset_mode)
      begin
        powerdown_flag_n_reg <= !halted;
      end
    end
    else if (enter_halt)
    begin
      timeout_flag_n_reg <= 1'b1;
      powerdown_flag_n_reg <= 1'b0;
    end
    else if (watchdog_clear_instruction && state_reg == pmrs_pkg::ST_RUN)
    begin
      timeout_flag_n_reg <= 1'b1;
      powerdown_flag_n_reg <= 1'b1;
    end
  end

  // ****************************************
  // Interrupt enable and wake events
  // ****************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      global_irq_enable_reg <= 1'b0;
    end
    else if (rst_evt || in_reset)
    begin
      global_irq_enable_reg <= 1'b0;
    end
    else if (state_reg == pmrs_pkg::ST_RUN && irq_enable_instruction)
    begin
      global_irq_enable_reg <= 1'b1;
    end
    else if (state_reg == pmrs_pkg::ST_RUN && irq_disable_instruction)
    begin
      global_irq_enable_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wdt_clear_reg <= 1'b0;
      irq_vector_reg <= 1'b0;
    end
    else
    begin
      wdt_clear_reg <= enter_halt || (watchdog_clear_instruction
        && state_reg == pmrs_pkg::ST_RUN && !rst_evt);
      irq_vector_reg <= !rst_evt && global_irq_enable_reg
        && ((state_reg == pmrs_pkg::ST_STANDBY && stby_wake)
        || (state_reg == pmrs_pkg::ST_WAKE
        && cnt_reg == `PMRS_WAKE_CYC));
    end
  end

  // ****************************************
  // Instruction clock divider
  // ****************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      div_reg <= 2'h0;
    end
    else if (!cpu_run)
    begin
      div_reg <= 2'h0;
    end
    else
    begin
      div_reg <= cfg.inst_div4 ? div_reg + 2'h1 : {1'b0, ~div_reg[0]};
    end
  end

  assign inst_tick = cpu_run
    && (cfg.inst_div4 ? (div_reg == 2'h3) : div_reg[0]);

  // ****************************************
  // APB slave
  // ****************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end
    else if (psel && penable && !pready_reg)
    begin
      pready_reg <= 1'b1;
      pslverr_reg <= !mapped;
      if (!pwrite && paddr == `PMRS_CTRL_OFS)
      begin
        prdata_reg <= {27'h0, low_clock_to_timer0_reg, power_mode_field_reg,
          fast_osc_stop_reg, fast_osc_select_reg};
      end
      else if (!pwrite && paddr == `PMRS_STAT_OFS)
      begin
        prdata_reg <= {27'h0, timeout_flag_n_reg, powerdown_flag_n_reg,
          state_reg};
      end
      else
      begin
        prdata_reg <= 32'h0;
      end
    end
    else
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ****************************************
  // Outputs
  // ****************************************
  assign core_reset = in_reset;
  assign cpu_run = (state_reg == pmrs_pkg::ST_RUN);
  assign sys_clk_fast = in_reset ? cfg.startup_fast
    : fast_osc_select_reg;
  assign fast_osc_en = (state_reg != pmrs_pkg::ST_HALT)
    && (in_reset ? cfg.startup_fast : !fast_osc_stop_reg);
  assign slow_osc_en = (state_reg != pmrs_pkg::ST_HALT);
  assign periph_en = cpu_run || (state_reg == pmrs_pkg::ST_STANDBY);
  assign timer0_en = periph_en && timer0_run;
  assign timer1_en = periph_en && timer1_run;
  assign timer0_slow_clk = low_clock_to_timer0_reg && cfg.tmr0_src;
  assign wdt_active = cfg.wdt_option && watchdog_run_enable;
  assign wdt_clear = wdt_clear_reg;
  assign irq_vector = irq_vector_reg;

  // ****************************************
  // Assertions
  // ****************************************
  logic wake_seen_reg;
  logic [4:0] wake_len_reg;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wake_seen_reg <= 1'b0;
      wake_len_reg <= 5'h00;
    end
    else if (rst_evt || cpu_run)
    begin
      wake_seen_reg <= 1'b0;
      wake_len_reg <= 5'h00;
    end
    else if (state_reg == pmrs_pkg::ST_HALT && halt_wake)
    begin
      wake_seen_reg <= 1'b1;
      wake_len_reg <= 5'h00;
    end
    else if (wake_seen_reg)
    begin
      wake_len_reg <= wake_len_reg + 5'h01;
    end
  end

  a_halt_wake_wait: assert property (@(posedge core_clk) disable iff (rst)
    (wake_seen_reg && cpu_run) |-> wake_len_reg == `PMRS_WAKE_CYC + 5'h01)
    else $error("halt wake wait wrong");
  a_stby_wake_now: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == pmrs_pkg::ST_STANDBY && stby_wake && !rst_evt) |=> cpu_run)
    else $error("standby wake late");
  a_halt_osc_off: assert property (@(posedge core_clk) disable iff (rst)
    state_reg == pmrs_pkg::ST_HALT |-> !fast_osc_en && !slow_osc_en && !timer0_en)
    else $error("halt clocks on");
  a_halt_timer_nowake: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == pmrs_pkg::ST_HALT && !halt_wake && !rst_evt)
    |=> state_reg == pmrs_pkg::ST_HALT)
    else $error("halt woke on timer");
  a_halt_entry_flags: assert property (@(posedge core_clk) disable iff (rst)
    enter_halt |=> timeout_flag_n_reg && !powerdown_flag_n_reg && wdt_clear)
    else $error("halt entry flags");
  a_ost_release: assert property (@(posedge core_clk) disable iff (rst)
    $fell(core_reset) |-> $past(state_reg == pmrs_pkg::ST_OST, 1)
    && $past(state_reg == pmrs_pkg::ST_OST, 16))
    else $error("start-up count short");
  a_start_mode: assert property (@(posedge core_clk) disable iff (rst)
    $fell(core_reset) |-> sys_clk_fast == cfg.startup_fast)
    else $error("startup clock wrong");
  a_sel_switch: assert property (@(posedge core_clk) disable iff (rst)
    (wr_ctrl && !rst_evt) |=> sys_clk_fast == $past(pwdata[0]))
    else $error("clock select ignored");
  a_reset_hold: assert property (@(posedge core_clk) disable iff (rst)
    rst_evt |=> core_reset && !cpu_run)
    else $error("reset event ignored");
  a_vector_gie: assert property (@(posedge core_clk) disable iff (rst)
    irq_vector |-> cpu_run && global_irq_enable_reg)
    else $error("vector without enable");
  a_wdt_flags: assert property (@(posedge core_clk) disable iff (rst)
    (wdt_timeout && cfg.wdt_reset_mode && reset_pin_n && !por_event
    && !low_voltage_reset && halted) |=> !timeout_flag_n_reg && !powerdown_flag_n_reg)
    else $error("watchdog flags wrong");

endmodule
`default_nettype wire

/* File: rtl/pmrs_consts.svh */
`ifndef PMRS_CONSTS_SVH
`define PMRS_CONSTS_SVH
`define PMRS_CLK_PS 4000
`define PMRS_PWRUP0_PS 64'd140000000
`define PMRS_PWRUP1_PS 64'd4500000000
`define PMRS_PWRUP2_PS 64'd18000000000
`define PMRS_PWRUP3_PS 64'd72000000000
`define PMRS_PWRUP4_PS 64'd288000000000
`define PMRS_OST_CYC 4'hF
`define PMRS_WAKE_CYC 4'hF
`define PMRS_CTRL_OFS 8'h00
`define PMRS_STAT_OFS 8'h04
`define PMRS_SEL_BIT 0
`define PMRS_STOP_BIT 1
`define PMRS_MODE_LSB 2
`define PMRS_LCK_BIT 4
`define PMRS_PD_BIT 3
`define PMRS_TO_BIT 4
`define PMRS_MODE_RUN 2'h0
`define PMRS_MODE_HALT 2'h1
`define PMRS_MODE_STBY 2'h2
`endif

/* File: rtl/pmrs_pkg.sv */
package pmrs_pkg;
  typedef enum logic [2:0]
  {
    ST_RESET,
    ST_PWRUP,
    ST_OST,
    ST_RUN,
    ST_STANDBY,
    ST_HALT,
    ST_WAKE
  } pmrs_state_e;
  typedef struct packed
  {
    logic t0_ovf;
    logic t1_unf;
    logic wdt_irq;
    logic pb_change;
    logic ext_irq;
    logic lvd_irq;
  } pmrs_wake_s;
  typedef struct packed
  {
    logic startup_fast;
    logic [2:0] pwrup_sel;
    logic inst_div4;
    logic wdt_reset_mode;
    logic wdt_option;
    logic tmr0_src;
  } pmrs_cfg_s;
endpackage

/* File: test/power_mode_and_reset_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pmrs_consts.svh"
module power_mode_and_reset_sequencer_bench;
  // ****************
  // Signals
  // ****************
  typedef struct packed {logic [7:0] wd; logic fast; logic fosc; logic t0s;} pmrs_row_s;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, er, vec, clr_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic por_event, low_voltage_reset, reset_pin_n, wdt_timeout;
  pmrs_pkg::pmrs_cfg_s cfg;
  pmrs_pkg::pmrs_wake_s wake;
  logic halt_instruction, watchdog_clear_instruction;
  logic irq_enable_instruction, irq_disable_instruction;
  logic timer0_run, timer1_run, watchdog_run_enable;
  logic core_reset, cpu_run, inst_tick, sys_clk_fast, fast_osc_en, slow_osc_en;
  logic timer0_en, timer1_en, timer0_slow_clk, periph_en, wdt_active, wdt_clear, irq_vector;
  int failures, checks, cyc, n, i;
  pmrs_row_s rows [6] = '{'{8'h01, 1'h1, 1'h1, 1'h0}, '{8'h11, 1'h1, 1'h1, 1'h1},
    '{8'h00, 1'h0, 1'h1, 1'h0}, '{8'h02, 1'h0, 1'h0, 1'h0},
    '{8'h00, 1'h0, 1'h1, 1'h0}, '{8'h01, 1'h1, 1'h1, 1'h0}};

  pmrs_top #(.PWRUP0_CYC(8), .PWRUP1_CYC(8), .PWRUP2_CYC(8), .PWRUP3_CYC(8),
    .PWRUP4_CYC(8)) u_dut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .por_event(por_event),
    .low_voltage_reset(low_voltage_reset), .reset_pin_n(reset_pin_n),
    .wdt_timeout(wdt_timeout), .cfg(cfg), .wake(wake),
    .halt_instruction(halt_instruction),
    .watchdog_clear_instruction(watchdog_clear_instruction),
    .irq_enable_instruction(irq_enable_instruction),
    .irq_disable_instruction(irq_disable_instruction), .timer0_run(timer0_run),
    .timer1_run(timer1_run), .watchdog_run_enable(watchdog_run_enable),
    .core_reset(core_reset), .cpu_run(cpu_run), .inst_tick(inst_tick),
    .sys_clk_fast(sys_clk_fast), .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en),
    .timer0_en(timer0_en), .timer1_en(timer1_en), .timer0_slow_clk(timer0_slow_clk),
    .periph_en(periph_en), .wdt_active(wdt_active), .wdt_clear(wdt_clear),
    .irq_vector(irq_vector));

  // ****************
  // Clock, timeout and helpers
  // ****************
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      results();
    end
  end

  always @(negedge core_clk)
    if (wdt_clear === 1'b1)
      clr_seen = 1'b1;

  task results;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task flg(input logic [1:0] e);
    apb(1'b0, `PMRS_STAT_OFS, 32'h0);
    chk(32'(rd[4:3]), 32'(e));
  endtask

  task wait_run;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end while (cpu_run !== 1'b1 && n < 300);
    vec = irq_vector;
  endtask

  task instr(input int k);
    @(posedge core_clk);
    case (k)
      0: halt_instruction <= 1'b1;
      1: watchdog_clear_instruction <= 1'b1;
      2: irq_enable_instruction <= 1'b1;
      default: irq_disable_instruction <= 1'b1;
    endcase
    @(posedge core_clk);
    {halt_instruction, watchdog_clear_instruction} <= 2'h0;
    {irq_enable_instruction, irq_disable_instruction} <= 2'h0;
  endtask

  task ev(input int k);
    @(posedge core_clk);
    case (k)
      0: por_event <= 1'b1;
      1: low_voltage_reset <= 1'b1;
      2: reset_pin_n <= 1'b0;
      default: wdt_timeout <= 1'b1;
    endcase
    @(posedge core_clk);
    {por_event, low_voltage_reset, wdt_timeout} <= 3'h0;
    reset_pin_n <= 1'b1;
    wait_run();
    chk(32'(n >= 22 && n <= 28), 32'h1);
  endtask

  task wake_by(input logic [5:0] w);
    @(posedge core_clk);
    wake <= w;
    wait_run();
    @(posedge core_clk);
    wake <= '0;
  endtask

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, cyc, failures, checks, clr_seen} = '0;
    {por_event, low_voltage_reset, wdt_timeout, wake} = '0;
    reset_pin_n = 1'b1;
    cfg = '{1'h1, 3'h0, 1'h0, 1'h1, 1'h1, 1'h1};
    {halt_instruction, watchdog_clear_instruction} = 2'h0;
    {irq_enable_instruction, irq_disable_instruction} = 2'h0;
    {timer0_run, timer1_run, watchdog_run_enable} = 3'b101;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    chk({core_reset, cpu_run, slow_osc_en, fast_osc_en}, 4'b1011);
    @(posedge core_clk);
    rst <= 1'b0;
    wait_run();
    chk(32'(n >= 24 && n <= 27), 32'h1);
    chk(sys_clk_fast, 1'b1);
    flg(2'b11);
    for (i = 0; i < 6; i++)
    begin
      apb(1'b1, `PMRS_CTRL_OFS, 32'(rows[i].wd));
      @(negedge core_clk);
      chk({sys_clk_fast, fast_osc_en, timer0_slow_clk, slow_osc_en},
          {rows[i].fast, rows[i].fosc, rows[i].t0s, 1'b1});
      apb(1'b0, `PMRS_CTRL_OFS, 32'h0);
      chk(32'(rd[4:0]), 32'(rows[i].wd[4:0]));
    end
    apb(1'b0, 8'h08, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, `PMRS_STAT_OFS, 32'h0);
    flg(2'b11);
    for (i = 0; i < 2; i++)
    begin
      @(posedge core_clk);
      cfg.inst_div4 <= 1'(i);
      repeat (4) @(posedge core_clk);
      n = 0;
      repeat (40)
      begin
        @(negedge core_clk);
        n += int'(inst_tick);
      end
      chk(n, i ? 10 : 20);
    end
    @(posedge core_clk);
    cfg.inst_div4 <= 1'b0;
    instr(2);
    for (i = 0; i < 6; i++)
    begin
      apb(1'b1, `PMRS_CTRL_OFS, 32'h09);
      repeat (2) @(negedge core_clk);
      chk({cpu_run, slow_osc_en, fast_osc_en, timer0_en, timer1_en}, 5'b01110);
      wake_by(6'(1 << i));
      chk(32'(n <= 3), 32'h1);
      chk(vec, 1'b1);
      chk(sys_clk_fast, 1'b1);
      apb(1'b0, `PMRS_CTRL_OFS, 32'h0);
      chk(32'(rd[3:0]), 32'h1);
    end
    instr(3);
    for (i = 1; i < 4; i++)
    begin
      clr_seen = 1'b0;
      if (i == 2)
        apb(1'b1, `PMRS_CTRL_OFS, 32'h05);
      else
        instr(0);
      repeat (2) @(negedge core_clk);
      chk({cpu_run, fast_osc_en, slow_osc_en, timer0_en, timer1_en, periph_en, wdt_active},
          7'b0000001);
      chk(clr_seen, 1'b1);
      flg(2'b10);
      if (i == 1)
      begin
        @(posedge core_clk);
        wake <= 6'h31;
        repeat (20) @(posedge core_clk);
        chk(cpu_run, 1'b0);
        wake <= '0;
      end
      wake_by(6'(1 << i));
      chk(32'(n >= 17 && n <= 19), 32'h1);
      chk(vec, 1'b0);
      apb(1'b0, `PMRS_CTRL_OFS, 32'h0);
      chk(32'(rd[3:0]), 32'h1);
    end
    apb(1'b1, `PMRS_CTRL_OFS, 32'h00);
    apb(1'b1, `PMRS_CTRL_OFS, 32'h06);
    repeat (2) @(negedge core_clk);
    chk(cpu_run, 1'b0);
    wake_by(6'h02);
    chk({sys_clk_fast, fast_osc_en}, 2'b00);
    apb(1'b0, `PMRS_CTRL_OFS, 32'h0);
    chk(32'(rd[3:0]), 32'h2);
    apb(1'b1, `PMRS_CTRL_OFS, 32'h00);
    apb(1'b1, `PMRS_CTRL_OFS, 32'h01);
    ev(3);
    flg(2'b01);
    ev(2);
    flg(2'b01);
    instr(0);
    ev(2);
    flg(2'b11);
    instr(0);
    ev(3);
    flg(2'b00);
    instr(1);
    flg(2'b11);
    instr(0);
    ev(1);
    flg(2'b11);
    instr(0);
    ev(0);
    flg(2'b11);
    chk(sys_clk_fast, 1'b1);
    @(posedge core_clk);
    cfg.wdt_reset_mode <= 1'b0;
    wdt_timeout <= 1'b1;
    @(posedge core_clk);
    wdt_timeout <= 1'b0;
    @(negedge core_clk);
    chk({core_reset, cpu_run}, 2'b01);
    flg(2'b01);
    @(posedge core_clk);
    cfg.wdt_reset_mode <= 1'b1;
    cfg.startup_fast <= 1'b0;
    ev(0);
    chk({sys_clk_fast, fast_osc_en}, 2'b01);
    results();
  end
endmodule
`default_nettype wire
